// ==== dss_consts.svh ====
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH

// Clock
`define DSS_CLK_PERIOD_NS    20
// Per-channel switching rate; the oscillator runs at twice this
`define DSS_FSW_KHZ          600
`define DSS_OSC_CYC          ((1000000 / (`DSS_CLK_PERIOD_NS * 2 * `DSS_FSW_KHZ)))
// Master-to-slave sequencing delay
`define DSS_SEQ_DELAY_US     400
`define DSS_SEQ_DELAY_CYC    ((`DSS_SEQ_DELAY_US * 1000) / `DSS_CLK_PERIOD_NS)
// Soft-start ramp, 0 V to the 0.8 V reference
`define DSS_SS_TIME_US       2100
`define DSS_REF_MV           800
`define DSS_REF_CODE         8'hff
`define DSS_SS_STEP_CYC      ((`DSS_SS_TIME_US * 1000) / (`DSS_CLK_PERIOD_NS * 255))
// Pulses dropped after a current-limit hit
`define DSS_SKIP_PULSES      3'h6
// Reset values
`define DSS_RST_CODE         8'h00

`endif

// ==== dss_pkg.sv ====
package dss_pkg;

    typedef enum logic [2:0]
    {
        DSS_MODE_2_FIRST = 3'h1,
        DSS_MODE_1_FIRST = 3'h2,
        DSS_MODE_INDEP   = 3'h4
    } dss_mode_t;

    typedef enum logic [2:0]
    {
        DSS_ST_OFF  = 3'h1,
        DSS_ST_BIAS = 3'h2,
        DSS_ST_ON   = 3'h4
    } dss_state_t;

endpackage : dss_pkg

// ==== dss_ch_if.sv ====
`timescale 1ns/1ps

interface dss_ch_if;
    logic       run;
    logic       slot;
    logic       cur_lim;
    logic [7:0] ref_code;
    logic       ramp_done;
    logic       pulse_start;
    logic       high_side_en;

    modport ctrl
    (
        output run,
        output slot,
        output cur_lim,
        input  ref_code,
        input  ramp_done,
        input  pulse_start,
        input  high_side_en
    );

    modport chan
    (
        input  run,
        input  slot,
        input  cur_lim,
        output ref_code,
        output ramp_done,
        output pulse_start,
        output high_side_en
    );
endinterface : dss_ch_if

// ==== dss_channel.sv ====
`timescale 1ns/1ps
`include "dss_consts.svh"

module dss_channel
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic nrst_i,
    // Channel link
    dss_ch_if.chan    ch
);

    localparam logic [8:0] STEP_CYC = 9'(`DSS_SS_STEP_CYC);

    logic [8:0] step_cnt;
    logic [7:0] ramp;
    logic [2:0] skip_cnt;
    logic       lim_seen;
    logic       pulse;

    // Step timer for the digital ramp
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !ch.run || step_cnt == STEP_CYC - 9'h1)
            step_cnt <= 9'h0;
        else
            step_cnt <= step_cnt + 9'h1;
    end

    // Ramp climbs from zero, then sits at the reference while enabled
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !ch.run)
            ramp <= `DSS_RST_CODE;
        else if (step_cnt == STEP_CYC - 9'h1 && ramp != `DSS_REF_CODE)
            ramp <= ramp + 8'h1;
    end

    // Lower of ramp and fixed reference governs the error amplifier
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !ch.run)
            ch.ref_code <= `DSS_RST_CODE;
        else
            ch.ref_code <= (ramp < `DSS_REF_CODE) ? ramp : `DSS_REF_CODE;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !ch.run)
            ch.ramp_done <= 1'b0;
        else if (ramp == `DSS_REF_CODE)
            ch.ramp_done <= 1'b1;
    end

    // Current-limit hit during soft-start, held until the next slot
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !ch.run)
            lim_seen <= 1'b0;
        else if (ch.cur_lim && !ch.ramp_done)
            lim_seen <= 1'b1;
        else if (ch.slot)
            lim_seen <= 1'b0;
    end

    // Drop six slots after a hit; none otherwise
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !ch.run)
            skip_cnt <= 3'h0;
        else if (ch.slot && lim_seen)
            skip_cnt <= `DSS_SKIP_PULSES - 3'h1;
        else if (ch.slot && skip_cnt != 3'h0)
            skip_cnt <= skip_cnt - 3'h1;
    end

    assign pulse = ch.run && ch.slot && !lim_seen && skip_cnt == 3'h0;

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            ch.pulse_start <= 1'b0;
        else
            ch.pulse_start <= pulse;
    end

    // Switch permission falls with the run request, no pulldown drive
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            ch.high_side_en <= 1'b0;
        else
            ch.high_side_en <= ch.run;
    end

endmodule : dss_channel

// ==== dss_top.sv ====
`timescale 1ns/1ps
`include "dss_consts.svh"
// How it works
// - Both enables low, strap floating: both outputs start once supply is valid, no extra delay.
// - Master or independent-mode enable released after regulation: high side off at once, pulldown stays off.
// - Strap sampled at power-on: high, low or floating selects the ordering mode.
// - Strap high: output 2 master, output 1 slave; enable 1 cannot start it.
// - Output-2-first: output 1 starts about 400 us after output 2 regulates.
// - Output-2-first: releasing enable 2 shuts both outputs at once.
// - Strap low: output 1 master, output 2 slave; enable 2 cannot start it.
// - Output-1-first: output 2 starts about 400 us after output 1 regulates.
// - Output-1-first: releasing enable 1 shuts both outputs at once.
// - Sequential, master off: slave enable alone keeps or drops the bias regulator.
// - Strap floating: each enable drives its own channel; tie them for ratiometric.
// - Ratiometric: each output ramps scaled to its final voltage, both arrive together.
// - Strap floating, separate enables: each output starts, runs, stops independently.
// - Each channel has its own stepped ramp; lower of ramp and reference governs.
// - Ramp goes from zero to the 0.8 V reference in about 2.1 ms.
// - Ramp holds at the reference while the output stays enabled.
// - In soft-start a current-limit hit drops the next six pulses.
// - No current-limit hit means no pulse is dropped.
// - Both enables released: shutdown, bias regulator off.
// - Bias must exceed 4 V before PWM and soft-start begin.
// - Channels switch on alternate oscillator cycles, 180 degrees apart.

module dss_top
#(
    parameter int SEQ_DELAY_CYC = `DSS_SEQ_DELAY_CYC
)
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Enable pins, active low
    input  wire logic       first_output_enable_n_i,
    input  wire logic       second_output_enable_n_i,
    // Order-select strap comparators
    input  wire logic       strap_at_bias_i,
    input  wire logic       strap_at_ground_i,
    // Supply monitors
    input  wire logic       control_supply_ok_i,
    input  wire logic       bias_above_4v_i,
    // Per-channel current-limit comparators
    input  wire logic [1:0] cur_lim_i,
    // Bias regulator control
    output logic            bias_reg_en_o,
    // Per-channel power stage
    output logic [1:0]      high_side_en_o,
    output logic [1:0]      pulldown_on_o,
    output logic [1:0]      pulse_start_o,
    output logic [1:0]      in_regulation_o,
    // Soft-start references
    output logic [7:0]      ch1_ref_code_o,
    output logic [7:0]      ch2_ref_code_o,
    // Status
    output logic [2:0]      mode_o
);

    localparam int         NSYNC   = 7;
    localparam logic [5:0] OSC_CYC = 6'(`DSS_OSC_CYC);

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;

    logic en1;
    logic en2;
    logic strap_hi;
    logic strap_lo;
    logic supply_ok;
    logic bias_ok;
    logic [1:0] lim;

    dss_pkg::dss_mode_t  mode;
    dss_pkg::dss_state_t state;
    dss_pkg::dss_state_t next_state;

    logic        strap_taken;
    logic [5:0]  osc_cnt;
    logic        osc_phase;
    logic        osc_tick;
    logic [14:0] delay_cnt;
    logic        delay_done;
    logic        master_reg;
    logic        want_bias;
    logic [1:0]  start_req;
    logic [1:0]  run;

    dss_ch_if ch_if [2] ();

    // Two-stage synchronisers for all pins
    assign raw_in = {cur_lim_i, bias_above_4v_i, control_supply_ok_i,
                     strap_at_ground_i, strap_at_bias_i,
                     first_output_enable_n_i ^ second_output_enable_n_i ^
                     second_output_enable_n_i};

    logic [1:0] en_raw_a;
    logic [1:0] en_raw_b;

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            sync_a   <= '0;
            sync_b   <= '0;
            en_raw_a <= 2'h3;
            en_raw_b <= 2'h3;
        end
        else
        begin
            sync_a   <= raw_in;
            sync_b   <= sync_a;
            en_raw_a <= {second_output_enable_n_i, first_output_enable_n_i};
            en_raw_b <= en_raw_a;
        end
    end

    assign en1       = !en_raw_b[0];
    assign en2       = !en_raw_b[1];
    assign strap_hi  = sync_b[1];
    assign strap_lo  = sync_b[2];
    assign supply_ok = sync_b[3];
    assign bias_ok   = sync_b[4];
    assign lim       = sync_b[6:5];

    // Strap caught once, at the first valid supply after reset
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            strap_taken <= 1'b0;
            mode        <= dss_pkg::DSS_MODE_INDEP;
        end
        else if (supply_ok && !strap_taken)
        begin
            strap_taken <= 1'b1;
            if (strap_hi)
                mode <= dss_pkg::DSS_MODE_2_FIRST;
            else if (strap_lo)
                mode <= dss_pkg::DSS_MODE_1_FIRST;
            else
                mode <= dss_pkg::DSS_MODE_INDEP;
        end
    end

    // Any asserted enable wants the bias regulator
    always_comb
    begin
        want_bias = supply_ok && strap_taken && (en1 || en2);
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            dss_pkg::DSS_ST_OFF:
                if (want_bias)
                    next_state = dss_pkg::DSS_ST_BIAS;
            dss_pkg::DSS_ST_BIAS:
                if (!want_bias)
                    next_state = dss_pkg::DSS_ST_OFF;
                else if (bias_ok)
                    next_state = dss_pkg::DSS_ST_ON;
            dss_pkg::DSS_ST_ON:
                if (!want_bias)
                    next_state = dss_pkg::DSS_ST_OFF;
                else if (!bias_ok)
                    next_state = dss_pkg::DSS_ST_BIAS;
            default:
                next_state = dss_pkg::DSS_ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            state <= dss_pkg::DSS_ST_OFF;
        else
            state <= next_state;
    end

    // Oscillator at twice the switching rate, slots alternate
    assign osc_tick = (osc_cnt == OSC_CYC - 6'h1);

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || osc_tick)
            osc_cnt <= 6'h0;
        else
            osc_cnt <= osc_cnt + 6'h1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            osc_phase <= 1'b0;
        else if (osc_tick)
            osc_phase <= !osc_phase;
    end

    // Master regulation starts the inter-channel delay
    always_comb
    begin
        unique case (mode)
            dss_pkg::DSS_MODE_2_FIRST: master_reg = ch_if[1].ramp_done;
            dss_pkg::DSS_MODE_1_FIRST: master_reg = ch_if[0].ramp_done;
            dss_pkg::DSS_MODE_INDEP:   master_reg = 1'b0;
            default:                   master_reg = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i || !master_reg)
            delay_cnt <= 15'h0;
        else if (!delay_done)
            delay_cnt <= delay_cnt + 15'h1;
    end

    assign delay_done = (delay_cnt == 15'(SEQ_DELAY_CYC));

    // Start requests per mode
    always_comb
    begin
        unique case (mode)
            dss_pkg::DSS_MODE_2_FIRST:
            begin
                start_req[1] = en2;
                start_req[0] = en2 && delay_done;
            end
            dss_pkg::DSS_MODE_1_FIRST:
            begin
                start_req[0] = en1;
                start_req[1] = en1 && delay_done;
            end
            dss_pkg::DSS_MODE_INDEP:
            begin
                start_req = {en2, en1};
            end
            default:
                start_req = 2'h0;
        endcase
    end

    // Runs only with bias good; both enables low start together in independent mode
    assign run = (state == dss_pkg::DSS_ST_ON) ? start_req : 2'h0;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            assign ch_if[g].run     = run[g];
            assign ch_if[g].slot    = osc_tick && (osc_phase == 1'(g));
            assign ch_if[g].cur_lim = lim[g];

            dss_channel u_ch
            (
                .sys_clk_i (sys_clk_i),
                .nrst_i    (nrst_i),
                .ch        (ch_if[g])
            );

            assign high_side_en_o[g]  = ch_if[g].high_side_en;
            assign pulse_start_o[g]   = ch_if[g].pulse_start;
            assign in_regulation_o[g] = ch_if[g].ramp_done;
            assign pulldown_on_o[g]   = 1'b0;
        end
    endgenerate

    // Each output takes its own channel's ramp code; divider scales each output
    assign ch1_ref_code_o = ch_if[0].ref_code;
    assign ch2_ref_code_o = ch_if[1].ref_code;

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            bias_reg_en_o <= 1'b0;
        else
            bias_reg_en_o <= (next_state != dss_pkg::DSS_ST_OFF);
    end

    assign mode_o = mode;

endmodule : dss_top

// ==== dss_top_properties.sv ====
`timescale 1ns/1ps

module dss_top_properties
#(
    parameter int SEQ_DELAY_CYC = 20000
)
(
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    // Pins
    input wire logic       first_output_enable_n_i,
    input wire logic       second_output_enable_n_i,
    input wire logic       strap_at_bias_i,
    input wire logic       strap_at_ground_i,
    input wire logic       control_supply_ok_i,
    input wire logic       bias_above_4v_i,
    input wire logic [1:0] cur_lim_i,
    // Outputs watched
    input wire logic       bias_reg_en_o,
    input wire logic [1:0] high_side_en_o,
    input wire logic [1:0] pulldown_on_o,
    input wire logic [1:0] pulse_start_o,
    input wire logic [1:0] in_regulation_o,
    input wire logic [7:0] ch1_ref_code_o,
    input wire logic [7:0] ch2_ref_code_o,
    input wire logic [2:0] mode_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_pd; pulldown_on_o == 2'h0; endproperty
    a_pd: assert property (p_pd) else $error("pulldown driven");
    property p_hs_drop;
        mode_o != 3'h1 && $rose(first_output_enable_n_i) |-> ##[1:5] !high_side_en_o[0];
    endproperty
    a_hs_drop: assert property (p_hs_drop) else $error("ch1 kept on");
    property p_seq2;
        mode_o == 3'h1 && $rose(second_output_enable_n_i) |-> ##[1:5] high_side_en_o == 2'h0;
    endproperty
    a_seq2: assert property (p_seq2) else $error("master 2 release");
    property p_seq1;
        mode_o == 3'h2 && $rose(first_output_enable_n_i) |-> ##[1:5] high_side_en_o == 2'h0;
    endproperty
    a_seq1: assert property (p_seq1) else $error("master 1 release");
    property p_off;
        (first_output_enable_n_i && second_output_enable_n_i) [*6] |-> !bias_reg_en_o;
    endproperty
    a_off: assert property (p_off) else $error("bias on in shutdown");
    property p_hold;
        in_regulation_o[0] |-> ch1_ref_code_o == 8'hff;
    endproperty
    a_hold: assert property (p_hold) else $error("ramp not held");
    property p_step;
        ch1_ref_code_o != $past(ch1_ref_code_o) |->
            ch1_ref_code_o == $past(ch1_ref_code_o) + 8'h01 || ch1_ref_code_o == 8'h00;
    endproperty
    a_step: assert property (p_step) else $error("ramp jump");
    property p_bias;
        $rose(high_side_en_o[0]) |-> bias_reg_en_o && $past(bias_above_4v_i, 2);
    endproperty
    a_bias: assert property (p_bias) else $error("start without bias");
    property p_slave;
        mode_o == 3'h2 && $rose(in_regulation_o[0]) |-> !high_side_en_o[1] [*8];
    endproperty
    a_slave: assert property (p_slave) else $error("slave early");
    property p_skip;
        $rose(cur_lim_i[0]) && high_side_en_o[0] && !in_regulation_o[0]
            |-> ##4 !pulse_start_o[0] [*8];
    endproperty
    a_skip: assert property (p_skip) else $error("pulse after hit");
    property p_alt; pulse_start_o != 2'h3; endproperty
    a_alt: assert property (p_alt) else $error("same slot");
endmodule : dss_top_properties

bind dss_top dss_top_properties #(.SEQ_DELAY_CYC(SEQ_DELAY_CYC)) u_props
(
    .sys_clk_i, .nrst_i, .first_output_enable_n_i, .second_output_enable_n_i,
    .strap_at_bias_i, .strap_at_ground_i, .control_supply_ok_i, .bias_above_4v_i,
    .cur_lim_i, .bias_reg_en_o, .high_side_en_o, .pulldown_on_o, .pulse_start_o,
    .in_regulation_o, .ch1_ref_code_o, .ch2_ref_code_o, .mode_o
);

// ==== dss_pin_model.sv ====
`timescale 1ns/1ps

module dss_pin_model
(
    // Requests: strap 0 floating, 1 bias, 2 ground
    input  wire logic       sys_clk_i,
    input  wire logic [1:0] strap_sel_i,
    input  wire logic [1:0] en_req_i,
    input  wire logic       tie_i,
    // Pins
    output logic            en1_n_o,
    output logic            en2_n_o,
    output logic            at_bias_o,
    output logic            at_gnd_o
);
    initial
    begin
        {en1_n_o, en2_n_o, at_bias_o, at_gnd_o} = 4'h c;
    end

    // Enable 2 follows the enable 1 request when tied
    always @(posedge sys_clk_i)
    begin
        #2;
        en1_n_o   <= !en_req_i[0];
        en2_n_o   <= tie_i ? !en_req_i[0] : !en_req_i[1];
        at_bias_o <= (strap_sel_i == 2'h1);
        at_gnd_o  <= (strap_sel_i == 2'h2);
    end
endmodule : dss_pin_model

// ==== dss_top_tb_top.sv ====
`timescale 1ns/1ps

module dss_top_tb_top;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, sup = 1'b1, b4 = 1'b1, tie = 1'b0;
    logic [1:0] sel = 2'h0, req = 2'h0, cl = 2'h0;
    logic e1, e2, sb, sg, bias, mode_ok;
    logic [1:0] hs, pd, ps, reg_ok;
    logic [7:0] r1, r2;
    logic [2:0] mode;
    int err_total = 0, checked = 0, n;

    always #10 sys_clk_i = ~sys_clk_i;

    dss_pin_model u_pins (.sys_clk_i(sys_clk_i), .strap_sel_i(sel), .en_req_i(req),
        .tie_i(tie), .en1_n_o(e1), .en2_n_o(e2), .at_bias_o(sb), .at_gnd_o(sg));
    dss_top #(.SEQ_DELAY_CYC(50)) u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .first_output_enable_n_i(e1), .second_output_enable_n_i(e2),
        .strap_at_bias_i(sb), .strap_at_ground_i(sg), .control_supply_ok_i(sup),
        .bias_above_4v_i(b4), .cur_lim_i(cl), .bias_reg_en_o(bias), .high_side_en_o(hs),
        .pulldown_on_o(pd), .pulse_start_o(ps), .in_regulation_o(reg_ok),
        .ch1_ref_code_o(r1), .ch2_ref_code_o(r2), .mode_o(mode));

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #2;
    endtask : step

    task automatic do_reset(input logic [1:0] s);
        nrst_i = 1'b0;
        req = 2'h0;
        sel = s;
        step(6);
        nrst_i = 1'b1;
        step(6);
    endtask : do_reset

    // Bounded wait on high-side (0,1) or regulation (2,3) flags
    task automatic wait_bit(input int idx, input int lim, output int cnt);
        cnt = 0;
        while (((idx < 2) ? hs[idx] : reg_ok[idx - 2]) !== 1'b1 && cnt < lim)
        begin
            step(1);
            cnt++;
        end
        if (cnt >= lim)
        begin
            err_total++;
            $display("MISMATCH t=%0t wait ran out", $time);
            print_verdict();
        end
    endtask : wait_bit

    // Pulses of channel 1 over a window
    task automatic count_ps(input int k, output int cnt);
        cnt = 0;
        repeat (k)
        begin
            step(1);
            cnt += ps[0];
        end
    endtask : count_ps

    task automatic t_indep;
        do_reset(2'h0);
        tie = 1'b1;
        req = 2'h3;
        step(8);
        chk(mode, 3'h4, "floating strap mode");
        chk(hs, 2'h3, "both start at once");
        step(900);
        chk(r2, r1, "ramps together");
        tie = 1'b0;
        req = 2'h1;
        step(6);
        chk(hs, 2'h1, "ch2 stops alone");
        chk(pd, 2'h0, "pulldown stays off");
        req = 2'h0;
        step(6);
        chk(bias, 1'b0, "shutdown");
        $display("test indep done");
    endtask : t_indep

    task automatic t_out2_first;
        do_reset(2'h1);
        req = 2'h1;
        step(8);
        chk(mode, 3'h1, "bias strap mode");
        chk(hs, 2'h0, "slave enable ignored");
        chk(bias, 1'b1, "slave keeps bias");
        req = 2'h3;
        wait_bit(1, 20, n);
        chk(hs[0], 1'b0, "slave waits");
        req = 2'h1;
        step(6);
        chk(hs, 2'h0, "master release stops both");
        chk(bias, 1'b1, "bias held by slave");
        $display("test out2 first done");
    endtask : t_out2_first

    task automatic t_out1_first;
        do_reset(2'h2);
        req = 2'h3;
        wait_bit(0, 20, n);
        chk(mode, 3'h2, "ground strap mode");
        chk(hs[1], 1'b0, "slave waits");
        cl = 2'h1;
        step(3);
        cl = 2'h0;
        count_ps(400, n);
        chk(n, 0, "pulses skipped");
        step(300);
        count_ps(410, n);
        chk(n, 5, "no skip without hit");
        wait_bit(2, 110000, n);
        chk(n > 102000 && n < 106000, 1'b1, "ramp time");
        chk(r1, 8'hff, "ramp end");
        wait_bit(1, 80, n);
        chk(n >= 48 && n <= 60, 1'b1, "slave delay");
        step(1000);
        chk(r1, 8'hff, "ramp held");
        req = 2'h2;
        step(6);
        chk(hs, 2'h0, "master release stops both");
        $display("test out1 first done");
    endtask : t_out1_first

    initial
    begin
        t_indep();
        t_out2_first();
        t_out1_first();
        print_verdict();
    end
endmodule : dss_top_tb_top
